//--- dv/udc_next_stage.sv
// Purpose: next cascaded stage, clocked by the ripple pulse
// Assumes: the pulse is sampled on aclk like any other pin
// Notes: ripple stage counts rises of its clock only, no enable of its own; lookahead stage is enabled
`timescale 1ns/1ps

module udc_next_stage
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // carry from the previous stage
    input wire logic ripple_pulse_n,
    // shared counter clock, global enable and flag for a lookahead stage
    input wire logic count_clk,
    input wire logic global_en_n,
    input wire logic terminal_flag,
    // stage state
    output logic [3:0] stage_count,
    output logic [3:0] look_count
);
    logic ripple_q;
    logic [3:0] stage_q;
    logic clk_q;
    logic [3:0] look_q;

    assign stage_count = stage_q;
    assign look_count = look_q;

    // lookahead stage: its enable gates the flag with the global enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_q <= 1'h0;
            look_q <= 4'h0;
        end
        else
        begin
            clk_q <= count_clk;
            if (count_clk && !clk_q && !global_en_n && terminal_flag)
                look_q <= look_q + 4'h1;
        end
    end

    // clocked from the ripple pulse, never from the spike-prone flag
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ripple_q <= 1'h1;
            stage_q <= 4'h0;
        end
        else
        begin
            ripple_q <= ripple_pulse_n;
            if (ripple_pulse_n && !ripple_q)
                stage_q <= stage_q + 4'h1;
        end
    end
endmodule

//--- dv/up_down_counter_4bit_preset_bench.sv
// Purpose: self-checking bench for the up/down counter
// Assumes: inputs change by nba at the aclk rise
// Notes: each pin step holds its levels until the next edge samples them
`timescale 1ns/1ps
`include "udc_defines.svh"

module up_down_counter_4bit_preset_bench;
    import udc_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    udc_pin_in_t pins_in = '{1'h1, 1'h1, 1'h0, 1'h0, 4'h0};
    udc_pin_out_t pins_out;
    logic [`UDC_ADDR_W-1:0] awaddr = 12'h000;
    logic [`UDC_ADDR_W-1:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] stage_count;
    logic [3:0] look_count;
    int num_errors = 0;
    int check_count = 0;

    always #12.5 aclk = ~aclk;

    udc_counter u_dut
    (
        .aclk(aclk), .aresetn(aresetn), .pins_in(pins_in), .pins_out(pins_out),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    udc_next_stage u_next
    (
        .aclk(aclk), .aresetn(aresetn), .ripple_pulse_n(pins_out.ripple_pulse_n),
        .count_clk(pins_in.count_clk), .global_en_n(pins_in.count_en_n),
        .terminal_flag(pins_out.terminal_flag), .stage_count(stage_count),
        .look_count(look_count)
    );

    task results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk_bus(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
            num_errors++;
        end
    endtask

    task tmo(input int n);
        if (n >= 50)
        begin
            $display("CHECK FAILED handshake expected answer seen none");
            num_errors++;
            results();
        end
    endtask

    // ctl is load_n, en_n, down, clk; fr is flag, ripple_n
    task st(input logic [3:0] ctl, input logic [3:0] pd, input logic [3:0] c,
            input logic [1:0] fr);
        @(posedge aclk);
        pins_in <= {ctl, pd};
        @(posedge aclk);
        #1;
        check_count++;
        if (pins_out !== {c, fr})
        begin
            $display("CHECK FAILED pins expected %h seen %h", {c, fr}, pins_out);
            num_errors++;
        end
    endtask

    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end
        while (!bvalid && n < 50);
        tmo(n);
        bready <= 1'h0;
        chk_bus("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'h0;
        end
        while (!rvalid && n < 50);
        tmo(n);
        rready <= 1'h0;
        chk_bus("rdata", ed, rdata);
        chk_bus("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    task t_load();
        st(4'hc, 4'h0, 4'h0, 2'h1);
        st(4'h1, 4'ha, 4'ha, 2'h1);
        st(4'h0, 4'ha, 4'ha, 2'h1);
        st(4'h1, 4'ha, 4'ha, 2'h1);
        st(4'h8, 4'ha, 4'ha, 2'h1);
    endtask

    // pulse cut short by enable, then a full wrap pulse
    task t_up();
        st(4'h4, 4'he, 4'he, 2'h1);
        st(4'h9, 4'he, 4'hf, 2'h3);
        st(4'h8, 4'he, 4'hf, 2'h2);
        st(4'hc, 4'he, 4'hf, 2'h3);
        st(4'h9, 4'he, 4'h0, 2'h1);
        st(4'h5, 4'hf, 4'hf, 2'h3);
        st(4'h8, 4'hf, 4'hf, 2'h2);
        st(4'h9, 4'hf, 4'h0, 2'h1);
    endtask

    task t_down();
        st(4'h6, 4'h1, 4'h1, 2'h1);
        st(4'hb, 4'h1, 4'h0, 2'h3);
        st(4'ha, 4'h1, 4'h0, 2'h2);
        st(4'hb, 4'h1, 4'hf, 2'h1);
    endtask

    task t_hold();
        st(4'hc, 4'h0, 4'hf, 2'h3);
        st(4'hd, 4'h0, 4'hf, 2'h3);
        st(4'hc, 4'h0, 4'hf, 2'h3);
        st(4'he, 4'h0, 4'hf, 2'h1);
        st(4'ha, 4'h0, 4'hf, 2'h1);
    endtask

    // three ripple pulses, one cut short by enable, reached the next stage; status holds f, ripple 1, down
    task t_regs();
        axi_rd(`UDC_STATUS_OFS, 32'h6f, `UDC_RESP_OKAY);
        axi_rd(`UDC_WRAPS_OFS, 32'h3, `UDC_RESP_OKAY);
        chk_bus("stage", 32'h3, {28'h0, stage_count});
        chk_bus("lookahead", 32'h3, {28'h0, look_count});
        axi_wr(`UDC_CTRL_OFS, 32'h51, `UDC_RESP_OKAY);
        st(4'ha, 4'h0, 4'h5, 2'h1);
        axi_rd(`UDC_CTRL_OFS, 32'h50, `UDC_RESP_OKAY);
        axi_wr(`UDC_STATUS_OFS, 32'hff, `UDC_RESP_OKAY);
        axi_rd(`UDC_STATUS_OFS, 32'h65, `UDC_RESP_OKAY);
        axi_wr(12'h00c, 32'h0, `UDC_RESP_SLVERR);
        axi_rd(12'h00c, 32'h0, `UDC_RESP_SLVERR);
    endtask

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_load();
        t_up();
        t_down();
        t_hold();
        t_regs();
        results();
    end
endmodule

//--- verilog/udc_counter.sv
// Purpose: 4-bit up/down counter with preset, terminal flag and ripple pulse
// Assumes: all pins synchronous to aclk; count_clk is a sampled input
// Notes: AXI4-Lite slave for software preset and status readback
//
// Operation
// - hold a 4-bit count in flip-flops
// - load low copies preset data, overriding all
// - enable high holds count unchanged
// - enabled count changes only on clock rise
// - direction low counts up, high down
// - count wraps modulo sixteen both ways
// - flag high at 15 up, 0 down
// - flag holds until count or direction changes
// - flag ignores the count enable input
// - ripple low from clock fall while enabled at terminal
// - enable high forces ripple output high
// - ripple returns high right after clock rises
`timescale 1ns/1ps
`include "udc_defines.svh"

module udc_counter
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // counter pins
    input wire udc_pkg::udc_pin_in_t pins_in,
    output udc_pkg::udc_pin_out_t pins_out,
    // axi4-lite write address and data
    input wire logic [`UDC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`UDC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import udc_pkg::*;

    logic [3:0] count_q;
    logic [3:0] count_d;
    logic terminal_flag_q;
    logic ripple_n_q;
    logic clk_prev_q;
    logic clk_rise;
    logic clk_fall;
    logic step;
    logic [15:0] wraps_q;
    logic sw_load_q;
    logic [3:0] sw_preset_q;

    function automatic logic flag_decode(input logic [3:0] cnt, input logic down);
        // independent of count enable by construction
        flag_decode = down ? (cnt == `UDC_COUNT_MIN) : (cnt == `UDC_COUNT_MAX);
    endfunction

    // edges of the sampled counter clock
    assign clk_rise = pins_in.count_clk & ~clk_prev_q;
    assign clk_fall = ~pins_in.count_clk & clk_prev_q;
    assign step = pins_in.async_load_n & ~sw_load_q & ~pins_in.count_en_n & clk_rise;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clk_prev_q <= 1'b0;
        else
            clk_prev_q <= pins_in.count_clk;
    end

    // load pin beats software load beats counting
    always_comb
    begin
        count_d = count_q;
        if (!pins_in.async_load_n)
            count_d = pins_in.preset_data;
        else if (sw_load_q)
            count_d = sw_preset_q;
        else if (step)
        begin
            if (pins_in.dir_down)
                count_d = count_q - 4'h1;
            else
                count_d = count_q + 4'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_q <= `UDC_COUNT_RST;
        else
            count_q <= count_d;
    end

    // registered so the pin is glitch free; direction shows one cycle late
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            terminal_flag_q <= 1'b0;
        else
            terminal_flag_q <= flag_decode(count_d, pins_in.dir_down);
    end

    // ripple pulse spans the low phase of the counter clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ripple_n_q <= 1'b1;
        else if (pins_in.count_en_n || !terminal_flag_q || clk_rise)
            ripple_n_q <= 1'b1;
        else if (clk_fall)
            ripple_n_q <= 1'b0;
    end

    // wraps seen by counting, free running
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wraps_q <= `UDC_WRAPS_RST;
        else if (step && flag_decode(count_q, pins_in.dir_down))
            wraps_q <= wraps_q + 16'h0001;
    end

    assign pins_out = '{count_value: count_q, terminal_flag: terminal_flag_q,
                        ripple_pulse_n: ripple_n_q};

    // axi4-lite write side
    logic aw_got_q;
    logic w_got_q;
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic aw_got_d;
    logic w_got_d;
    logic bvalid_d;
    logic [`UDC_ADDR_W-1:0] awaddr_q;
    logic [`UDC_ADDR_W-1:0] wr_addr;
    logic [31:0] wdata_q;
    logic [31:0] wr_data;
    logic [3:0] wstrb_q;
    logic [3:0] wr_strb;

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign do_write = (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~s_axi_bvalid;
    assign aw_got_d = (aw_got_q | aw_hs) & ~do_write;
    assign w_got_d = (w_got_q | w_hs) & ~do_write;
    assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            s_axi_awready <= ~aw_got_d & ~bvalid_d;
            s_axi_wready <= ~w_got_d & ~bvalid_d;
            s_axi_bvalid <= bvalid_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (aw_hs)
                awaddr_q <= s_axi_awaddr;
            if (w_hs)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // register writes; load bit is a strobe, preset field is stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bresp <= `UDC_RESP_OKAY;
            sw_load_q <= 1'b0;
            sw_preset_q <= `UDC_PRESET_RST;
        end
        else
        begin
            sw_load_q <= 1'b0;
            if (do_write)
            begin
                s_axi_bresp <= `UDC_RESP_OKAY;
                if (wr_addr[`UDC_ADDR_W-1:2] == `UDC_CTRL_OFS >> 2)
                begin
                    if (wr_strb[0])
                    begin
                        sw_preset_q <= wr_data[`UDC_CTRL_PRESET_MSB:`UDC_CTRL_PRESET_LSB];
                        sw_load_q <= wr_data[`UDC_CTRL_LOAD_BIT];
                    end
                end
                else if (wr_addr[`UDC_ADDR_W-1:2] != `UDC_STATUS_OFS >> 2 &&
                         wr_addr[`UDC_ADDR_W-1:2] != `UDC_WRAPS_OFS >> 2)
                    s_axi_bresp <= `UDC_RESP_SLVERR;
            end
        end
    end

    // axi4-lite read side
    udc_rd_state_t rd_state_q;
    logic [31:0] rd_mux;
    logic rd_hit;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr[`UDC_ADDR_W-1:2])
            `UDC_CTRL_OFS >> 2:
                rd_mux[`UDC_CTRL_PRESET_MSB:`UDC_CTRL_PRESET_LSB] = sw_preset_q;
            `UDC_STATUS_OFS >> 2:
            begin
                rd_mux[`UDC_STAT_COUNT_MSB:`UDC_STAT_COUNT_LSB] = count_q;
                rd_mux[`UDC_STAT_FLAG_BIT] = terminal_flag_q;
                rd_mux[`UDC_STAT_RIPPLE_BIT] = ripple_n_q;
                rd_mux[`UDC_STAT_DIR_BIT] = pins_in.dir_down;
            end
            `UDC_WRAPS_OFS >> 2:
                rd_mux[15:0] = wraps_q;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state_q <= UDC_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UDC_RESP_OKAY;
        end
        else
        begin
            case (rd_state_q)
                UDC_RD_IDLE:
                begin
                    s_axi_arready <= 1'b1;
                    if (s_axi_arvalid && s_axi_arready)
                    begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= rd_mux;
                        s_axi_rresp <= rd_hit ? `UDC_RESP_OKAY : `UDC_RESP_SLVERR;
                        rd_state_q <= UDC_RD_DATA;
                    end
                end
                UDC_RD_DATA:
                begin
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state_q <= UDC_RD_IDLE;
                    end
                end
                default:
                    rd_state_q <= UDC_RD_IDLE;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_load_copies;
        !pins_in.async_load_n |=> count_q == $past(pins_in.preset_data);
    endproperty
    a_load_copies: assert property (p_load_copies)
        else $error("preset data not loaded");

    property p_hold_disabled;
        pins_in.async_load_n && !sw_load_q && pins_in.count_en_n |=> $stable(count_q);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("count moved while disabled");

    property p_only_on_rise;
        pins_in.async_load_n && !sw_load_q && !clk_rise |=> $stable(count_q);
    endproperty
    a_only_on_rise: assert property (p_only_on_rise)
        else $error("count moved without clock rise");

    property p_count_up;
        step && !pins_in.dir_down |=> count_q == 4'($past(count_q) + 4'h1);
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("up count wrong");

    property p_count_down;
        step && pins_in.dir_down |=> count_q == 4'($past(count_q) - 4'h1);
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("down count wrong");

    property p_wrap;
        step && count_q == 4'hf && !pins_in.dir_down |=> count_q == 4'h0 && !terminal_flag_q;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("up wrap wrong");

    property p_flag_decode;
        1'b1 |=> terminal_flag_q == ($past(pins_in.dir_down) ? count_q == 4'h0 : count_q == 4'hf);
    endproperty
    a_flag_decode: assert property (p_flag_decode)
        else $error("terminal flag mismatch");

    property p_ripple_low;
        clk_fall && !pins_in.count_en_n && terminal_flag_q |=> !ripple_n_q;
    endproperty
    a_ripple_low: assert property (p_ripple_low)
        else $error("ripple pulse missing");

    property p_ripple_disabled;
        pins_in.count_en_n |=> ripple_n_q;
    endproperty
    a_ripple_disabled: assert property (p_ripple_disabled)
        else $error("ripple low while disabled");

    property p_ripple_release;
        !ripple_n_q && clk_rise |=> ripple_n_q;
    endproperty
    a_ripple_release: assert property (p_ripple_release)
        else $error("ripple not released on rise");

endmodule

//--- verilog/udc_defines.svh
// Purpose: constants of the up/down counter block (offsets, fields, resets)
// Assumes: included by its bare name wherever the constants are needed
// Notes: byte offsets on a 12-bit AXI4-Lite address
`ifndef UDC_DEFINES_SVH
`define UDC_DEFINES_SVH

`define UDC_ADDR_W 12
`define UDC_CTRL_OFS 12'h000
`define UDC_STATUS_OFS 12'h004
`define UDC_WRAPS_OFS 12'h008

`define UDC_CTRL_LOAD_BIT 0
`define UDC_CTRL_PRESET_LSB 4
`define UDC_CTRL_PRESET_MSB 7
`define UDC_CTRL_RST 32'h0000_0000
`define UDC_PRESET_RST 4'h0

`define UDC_STAT_COUNT_LSB 0
`define UDC_STAT_COUNT_MSB 3
`define UDC_STAT_FLAG_BIT 4
`define UDC_STAT_RIPPLE_BIT 5
`define UDC_STAT_DIR_BIT 6

`define UDC_COUNT_RST 4'h0
`define UDC_COUNT_MAX 4'hf
`define UDC_COUNT_MIN 4'h0
`define UDC_WRAPS_RST 16'h0000

`define UDC_RESP_OKAY 2'h0
`define UDC_RESP_SLVERR 2'h2

`endif

//--- verilog/udc_pkg.sv
// Purpose: types shared by the up/down counter block
// Assumes: constants live in udc_defines.svh
// Notes: pin groups travel as packed structs
package udc_pkg;

    // pins facing the surrounding logic
    typedef struct packed {
        logic async_load_n;
        logic count_en_n;
        logic dir_down;
        logic count_clk;
        logic [3:0] preset_data;
    } udc_pin_in_t;

    typedef struct packed {
        logic [3:0] count_value;
        logic terminal_flag;
        logic ripple_pulse_n;
    } udc_pin_out_t;

    typedef enum logic [0:0] {
        UDC_RD_IDLE = 1'b0,
        UDC_RD_DATA = 1'b1
    } udc_rd_state_t;

endpackage
